// *** pkg/fpg_regs.svh ***
// Purpose: Constants of the fieldbus process-word gateway
// Assumes: Included by fpg_pkg and by fpg_gateway
// Notes: Definitions only
`ifndef FPG_REGS_SVH
`define FPG_REGS_SVH
// Configuration byte codes
`define FPG_CFG_EMPTY 8'h00
`define FPG_CFG_HDR 8'hC0
`define FPG_CFG_PARAM_LEN 8'h87
// Word module: top three bits 110, five-bit length minus one below
`define FPG_CFG_WORD_FMT 3'h6
// Process word layout
`define FPG_WORDS_PER_DRV 3
`define FPG_MAX_WORDS 24
`define FPG_MAX_DRV 8
`define FPG_NUM_PARAMS 8
`endif

// *** pkg/fpg_pkg.sv ***
// Purpose: Types of the fieldbus process-word gateway
// Assumes: Header fpg_regs.svh holds the numbers
// Notes: State enum is one-hot
`include "fpg_regs.svh"
package fpg_pkg;
    typedef enum logic [4:0] {
        FPG_IDLE = 5'h01,
        FPG_SLOT0 = 5'h02,
        FPG_HDR = 5'h04,
        FPG_OUTL = 5'h08,
        FPG_INL = 5'h10
    } fpg_state_e;

    typedef logic [15:0] fpg_word_t;

    typedef struct packed {
        fpg_state_e st;
        logic bad;
        logic par_seen;
        logic not3;
        logic [7:0] pend;
        logic [7:0] words;
        logic [3:0] mods;
        logic cfg_ok;
        logic per_drive;
        logic [7:0] nwords;
        logic [3:0] ndrv;
        logic link_err;
        logic [7:0] bank;
        fpg_word_t [7:0] par;
        fpg_word_t par_rdata;
        logic par_ack;
        logic rd_valid;
        logic rd_zero;
    } fpg_state_s;
endpackage

// *** verilog/fpg_mem.sv ***
// Purpose: Double-banked process word store
// Assumes: One write and one read port, same clock
// Notes: Read data comes out of a register
`timescale 1ns/10ps
module fpg_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 48,
    parameter int AW = 6
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Storage without reset, contents set by the master
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// *** verilog/fpg_gateway.sv ***
// Purpose: Fieldbus process-word gateway, slave side
// Assumes: Config bytes and process words arrive already decoded from the link
// Notes: Double buffer per drive gives consistent blocks
`timescale 1ns/10ps
`include "fpg_regs.svh"
module fpg_gateway import fpg_pkg::*; #(
    parameter int MAX_WORDS = `FPG_MAX_WORDS,
    parameter int MAX_DRV = `FPG_MAX_DRV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Configuration byte stream from the link
    input wire logic cfg_start,
    input wire logic cfg_valid,
    input wire logic [7:0] cfg_byte,
    input wire logic cfg_last,
    // Link state
    input wire logic dx_start,
    input wire logic link_fault,
    output logic link_err,
    output logic cfg_ok,
    output logic per_drive,
    output logic [3:0] drv_count,
    // Process words from the master
    input wire logic pw_wr,
    input wire logic [4:0] pw_idx,
    input wire logic [15:0] pw_data,
    input wire logic pw_commit,
    input wire logic [2:0] pw_commit_drv,
    // Settings channel
    input wire logic par_req,
    input wire logic par_we,
    input wire logic [2:0] par_addr,
    input wire logic [15:0] par_wdata,
    output logic par_ack,
    output logic [15:0] par_rdata,
    // Downstream system bus side
    input wire logic drv_rd_req,
    input wire logic [2:0] drv_rd_drv,
    input wire logic [1:0] drv_rd_word,
    output logic drv_rd_valid,
    output logic [15:0] drv_rd_data
);
    fpg_state_s s_q, s_d;
    logic [15:0] mem_q;
    logic wr_ok;
    logic [5:0] wr_addr;
    logic [5:0] rd_addr;
    logic [4:0] rd_word;
    logic nwords_ok;

    // Drive that owns a word index
    function automatic logic [2:0] drv_of(input logic [4:0] idx);
        drv_of = 3'(idx / 5'(`FPG_WORDS_PER_DRV));
    endfunction

    // Drives needed for a word count, rounded up
    function automatic logic [3:0] ceil_drv(input logic [7:0] n);
        ceil_drv = 4'((n + 8'(`FPG_WORDS_PER_DRV - 1)) / 8'(`FPG_WORDS_PER_DRV));
    endfunction

    // Master writes go to the bank the drives do not see
    // no exchange before acceptance
    assign wr_ok = pw_wr && !s_q.link_err && (8'(pw_idx) < s_q.nwords);
    assign wr_addr = {~s_q.bank[drv_of(pw_idx)], pw_idx};
    // drive k owns words 3k to 3k+2
    // Widen before the product, a 3-bit product would wrap from drive 3 up
    assign rd_word = 5'(drv_rd_drv) * 5'(`FPG_WORDS_PER_DRV) + 5'(drv_rd_word);
    assign rd_addr = {s_q.bank[drv_rd_drv], rd_word};

    fpg_mem #(.WIDTH(16), .DEPTH(64), .AW(6)) u_mem (
        .clk(clk),
        .wr_en(wr_ok),
        .wr_addr(wr_addr),
        .wr_data(pw_data),
        .rd_addr(rd_addr),
        .rd_data(mem_q)
    );

    // Next state: parser, link lamp, banks, settings channel
    always_comb begin
        logic [5:0] n;
        logic [7:0] words_n;
        logic [3:0] mods_n;
        logic bad_n;
        logic not3_n;
        logic fine;
        n = '0;
        words_n = '0;
        mods_n = '0;
        bad_n = 1'b0;
        not3_n = 1'b0;
        fine = 1'b0;
        s_d = s_q;
        s_d.par_ack = 1'b0;
        s_d.rd_valid = 1'b0;
        if (cfg_start) begin
            // new set-up stops exchange until accepted
            s_d.st = FPG_SLOT0;
            s_d.bad = 1'b0;
            s_d.par_seen = 1'b0;
            s_d.not3 = 1'b0;
            s_d.words = '0;
            s_d.mods = '0;
            s_d.cfg_ok = 1'b0;
            s_d.link_err = 1'b1;
        end else if (cfg_valid) begin
            case (s_q.st)
                FPG_SLOT0: begin
                    if (cfg_byte != `FPG_CFG_EMPTY) s_d.bad = 1'b1;
                    s_d.st = FPG_HDR;
                end
                FPG_HDR: begin
                    if (cfg_byte != `FPG_CFG_HDR) s_d.bad = 1'b1;
                    s_d.st = FPG_OUTL;
                end
                FPG_OUTL: begin
                    s_d.pend = cfg_byte;
                    s_d.st = FPG_INL;
                end
                FPG_INL: begin
                    s_d.st = FPG_HDR;
                    // Five-bit length: C0 is one word, D7 is twenty-four
                    n = 6'(cfg_byte[4:0]) + 6'h01;
                    if (cfg_byte != s_q.pend) begin
                        s_d.bad = 1'b1;
                    end else if (cfg_byte == `FPG_CFG_PARAM_LEN) begin
                        // settings channel optional, once, before drives
                        if (s_q.par_seen || s_q.mods != 4'h0) s_d.bad = 1'b1;
                        s_d.par_seen = 1'b1;
                    end else if (cfg_byte[7:5] == `FPG_CFG_WORD_FMT) begin
                        s_d.words = s_q.words + 8'(n);
                        s_d.mods = s_q.mods + 4'h1;
                        if (n != 6'(`FPG_WORDS_PER_DRV)) s_d.not3 = 1'b1;
                    end else begin
                        s_d.bad = 1'b1;
                    end
                end
                default: s_d.bad = 1'b1;
            endcase
            if (cfg_last) begin
                words_n = s_d.words;
                mods_n = s_d.mods;
                bad_n = s_d.bad;
                not3_n = s_d.not3;
                // range and layout check, module not of three words rejected when there are several modules
                fine = !bad_n && (s_d.st == FPG_HDR) && (words_n >= 8'h01)
                    && (words_n <= 8'(MAX_WORDS)) && (mods_n <= 4'(MAX_DRV))
                    && !(mods_n > 4'h1 && not3_n);
                s_d.st = FPG_IDLE;
                s_d.cfg_ok = fine;
                // several modules means one block per drive
                s_d.per_drive = mods_n > 4'h1;
                s_d.nwords = fine ? words_n : 8'h00;
                // one drive per group of three words
                s_d.ndrv = fine ? ceil_drv(words_n) : 4'h0;
                s_d.bank = '0;
            end
        end
        // lamp off only with accepted config and exchange started
        if (link_fault || !s_d.cfg_ok) begin
            s_d.link_err = 1'b1;
        end else if (dx_start && s_q.cfg_ok && !cfg_start) begin
            s_d.link_err = 1'b0;
        end
        // Commit flips the visible bank
        if (pw_commit && !s_q.link_err) begin
            for (int k = 0; k < 8; k++) begin
                if (!s_q.per_drive && 4'(k) < s_q.ndrv) s_d.bank[k] = ~s_q.bank[k];
            end
            if (s_q.per_drive && 4'(pw_commit_drv) < s_q.ndrv) begin
                s_d.bank[pw_commit_drv] = ~s_q.bank[pw_commit_drv];
            end
        end
        // settings channel reaches gateway parameters only
        if (par_req) begin
            if (par_we) s_d.par[par_addr] = par_wdata;
            s_d.par_rdata = par_we ? par_wdata : s_q.par[par_addr];
            s_d.par_ack = 1'b1;
        end
        // Drive read; unmapped words read as zero
        if (drv_rd_req) begin
            s_d.rd_valid = 1'b1;
            s_d.rd_zero = s_q.link_err || (8'(rd_word) >= s_q.nwords)
                || (4'(drv_rd_drv) >= s_q.ndrv);
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '{st: FPG_IDLE, link_err: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs from the state register
    assign link_err = s_q.link_err;
    assign cfg_ok = s_q.cfg_ok;
    assign per_drive = s_q.per_drive;
    assign drv_count = s_q.ndrv;
    assign par_ack = s_q.par_ack;
    assign par_rdata = s_q.par_rdata;
    assign drv_rd_valid = s_q.rd_valid;
    // drive data only ever comes from process words
    assign drv_rd_data = s_q.rd_zero ? 16'h0000 : mem_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_lamp_after_reset: assert property ($fell(sys_rst) |-> link_err)
        else $error("lamp not lit after reset");
    a_lamp_needs_cfg: assert property (!link_err |-> cfg_ok)
        else $error("lamp off without accepted config");
    a_lamp_goes_off: assert property (
        cfg_ok && dx_start && !link_fault && !cfg_start && !(cfg_valid && cfg_last)
        |=> !link_err)
        else $error("lamp stayed lit after start");
    a_fault_lights_lamp: assert property (link_fault |=> link_err)
        else $error("lamp off during link fault");
    a_word_range: assert property (cfg_ok |-> nwords_ok)
        else $error("accepted word count out of range");
    a_drive_count: assert property (cfg_ok |-> drv_count == s_q.ndrv
        && drv_count == 4'((s_q.nwords + 8'h02) / 8'h03))
        else $error("drive count not words over three");
    a_reject_big: assert property (
        cfg_valid && cfg_last && !cfg_start && s_d.words > 8'(MAX_WORDS)
        |=> !cfg_ok ##1 link_err)
        else $error("oversized config accepted");
    a_no_write_idle: assert property (link_err |-> !wr_ok)
        else $error("process write before exchange");
    a_par_answer: assert property (par_req |=> par_ack)
        else $error("settings request unanswered");
    a_rd_answer: assert property (drv_rd_req |=> drv_rd_valid)
        else $error("drive read unanswered");
    a_single_flip: assert property (pw_commit && !link_err && !per_drive
        && drv_count > 4'h1 |=> s_q.bank[1] == s_q.bank[0])
        else $error("single block split between drives");

    assign nwords_ok = s_q.nwords >= 8'h01 && s_q.nwords <= 8'(MAX_WORDS);

    c_cfg_accept: cover property (!cfg_ok ##1 cfg_ok);
    c_per_drive: cover property (cfg_ok && per_drive && drv_count == 4'h8);
    c_exchange: cover property ($fell(link_err));
    c_reject: cover property (cfg_valid && cfg_last ##1 !cfg_ok);
endmodule

// *** dv/fpg_master_model.sv ***
// Purpose: Fieldbus master stand-in that sends configuration streams
// Assumes: Caller hands over the modules after the empty slot
// Notes: Byte lane shows A5 at first, then the inverted last byte, when no byte is valid
`timescale 1ns/10ps
module fpg_master_model (
    // Clock
    input wire logic clk,
    // Configuration stream
    output logic cfg_start,
    output logic cfg_valid,
    output logic cfg_last,
    output logic [7:0] cfg_byte
);
    // Idle lane at time zero
    initial begin
        cfg_start = 1'b0;
        cfg_valid = 1'b0;
        cfg_last = 1'b0;
        cfg_byte = 8'hA5;
    end

    task automatic send(input logic [7:0] q[$]);
        @(posedge clk);
        #1 cfg_start = 1'b1;
        q.push_front(8'h00);
        @(posedge clk);
        #1 cfg_start = 1'b0;
        foreach (q[i]) begin
            cfg_valid = 1'b1;
            cfg_byte = q[i];
            cfg_last = (i == q.size() - 1);
            @(posedge clk);
            #1;
        end
        cfg_valid = 1'b0;
        cfg_last = 1'b0;
        cfg_byte = ~cfg_byte; // Released lane must not look valid
    endtask
endmodule

// *** dv/testbench.sv ***
// Purpose: Self-checking bench of the process-word gateway
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Read answers are checked from a queue by a monitor
`timescale 1ns/10ps
module testbench;
    import fpg_pkg::*;
    logic clk = 0, sys_rst = 1, dx_start = 0, link_fault = 0, pw_wr = 0, pw_commit = 0;
    logic par_req = 0, par_we = 0, drv_rd_req = 0;
    logic [4:0] pw_idx = 0;
    logic [15:0] pw_data = 0, par_wdata = 0;
    logic [2:0] pw_commit_drv = 0, par_addr = 0, drv_rd_drv = 0;
    logic [1:0] drv_rd_word = 0;
    logic cfg_start, cfg_valid, cfg_last, link_err, cfg_ok, per_drive, par_ack, drv_rd_valid;
    logic [7:0] cfg_byte, rs = 8'h56;
    logic [3:0] drv_count;
    logic [15:0] par_rdata, drv_rd_data;
    logic [15:0] wv[24], exq[$];
    logic [7:0] cq[$];
    int fails = 0, comparisons = 0, cycles = 0;

    fpg_master_model mst (.clk(clk), .cfg_start(cfg_start), .cfg_valid(cfg_valid),
        .cfg_last(cfg_last), .cfg_byte(cfg_byte));
    fpg_gateway uut (.clk(clk), .sys_rst(sys_rst), .cfg_start(cfg_start),
        .cfg_valid(cfg_valid), .cfg_byte(cfg_byte), .cfg_last(cfg_last),
        .dx_start(dx_start), .link_fault(link_fault), .link_err(link_err), .cfg_ok(cfg_ok),
        .per_drive(per_drive), .drv_count(drv_count), .pw_wr(pw_wr), .pw_idx(pw_idx),
        .pw_data(pw_data), .pw_commit(pw_commit), .pw_commit_drv(pw_commit_drv),
        .par_req(par_req), .par_we(par_we), .par_addr(par_addr), .par_wdata(par_wdata),
        .par_ack(par_ack), .par_rdata(par_rdata), .drv_rd_req(drv_rd_req),
        .drv_rd_drv(drv_rd_drv), .drv_rd_word(drv_rd_word), .drv_rd_valid(drv_rd_valid),
        .drv_rd_data(drv_rd_data));

    // Clock and hang guard
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end

    // Random words from a small shift register
    function logic [15:0] rnd();
        rs = {rs[6:0], rs[7] ^ rs[5] ^ rs[4] ^ rs[3]};
        rnd[15:8] = rs;
        rs = {rs[6:0], rs[7] ^ rs[5] ^ rs[4] ^ rs[3]};
        rnd[7:0] = rs;
    endfunction

    task tick();
        @(posedge clk);
        #1;
    endtask

    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask

    task finish_test();
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Module list helpers, then the whole stream
    task modl(input logic [7:0] l);
        cq.push_back(8'hC0);
        cq.push_back(l);
        cq.push_back(l);
    endtask
    task cfg_go();
        mst.send(cq);
        cq.delete();
    endtask
    task cfg_chk(input logic ok, input logic pd, input logic [3:0] n);
        chk("cfg_ok", {15'h0, cfg_ok}, {15'h0, ok});
        chk("per_drive", {15'h0, per_drive}, {15'h0, pd});
        chk("drv_count", {12'h0, drv_count}, {12'h0, n});
    endtask
    task dx();
        dx_start = 1;
        tick();
        dx_start = 0;
    endtask
    task rd(input logic [2:0] d, input logic [1:0] w, input logic [15:0] e);
        exq.push_back(e);
        drv_rd_req = 1;
        drv_rd_drv = d;
        drv_rd_word = w;
        tick();
        drv_rd_req = 0;
        tick();
    endtask
    task par(input logic we, input logic [2:0] a, input logic [15:0] wd, input logic [15:0] e);
        exq.push_back(e);
        par_req = 1;
        par_we = we;
        par_addr = a;
        par_wdata = wd;
        tick();
        par_req = 0;
        tick();
    endtask
    task wr_blk(input int lo, input int hi, input logic [2:0] d);
        for (int i = lo; i <= hi; i++) begin
            pw_wr = 1;
            pw_idx = i[4:0];
            pw_data = wv[i];
            tick();
        end
        pw_wr = 0;
        pw_commit = 1;
        pw_commit_drv = d;
        tick();
        pw_commit = 0;
    endtask

    // Answer monitor, mid-cycle so registered answers have settled
    always @(negedge clk) begin
        if (drv_rd_valid === 1'b1 || par_ack === 1'b1) begin
            if (exq.size() == 0)
                chk("extra answer", 16'h1, 16'h0);
            else
                chk("answer", drv_rd_valid ? drv_rd_data : par_rdata, exq.pop_front());
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        #1 sys_rst = 0;
        dx();
        chk("lamp after reset", {15'h0, link_err}, 16'h1);
        for (int k = 0; k <= 8; k++) begin
            modl(k ? 8'(8'hC0 | (3 * k - 1)) : 8'hC0);
            cfg_go();
            cfg_chk(1'b1, 1'b0, k ? 4'(k) : 4'h1);
        end
        modl(8'hD8);
        cfg_go();
        cfg_chk(0, 0, 0);
        cq = '{8'hC0, 8'hC2, 8'hC5};
        cfg_go();
        cfg_chk(0, 0, 0);
        dx();
        chk("lamp bad cfg", {15'h0, link_err}, 16'h1);
        modl(8'h87);
        modl(8'hC2);
        modl(8'hC2);
        cfg_go();
        cfg_chk(1, 1, 2);
        dx();
        chk("lamp off", {15'h0, link_err}, 16'h0);
        foreach (wv[i]) wv[i] = rnd();
        wr_blk(0, 2, 3'h0);
        wr_blk(3, 5, 3'h1);
        rd(3'h1, 2'h0, wv[3]);
        rd(3'h0, 2'h2, wv[2]);
        for (int i = 0; i < 3; i++) wv[i] = ~wv[i];
        wr_blk(0, 2, 3'h0);
        rd(3'h0, 2'h0, wv[0]);
        rd(3'h1, 2'h0, wv[3]);
        for (int a = 0; a < 8; a++) wv[8 + a] = rnd();
        for (int a = 0; a < 8; a++) par(1, a[2:0], wv[8 + a], wv[8 + a]);
        for (int a = 0; a < 8; a++) par(0, a[2:0], 16'h0, wv[8 + a]);
        rd(3'h1, 2'h1, wv[4]);
        modl(8'hC5);
        cfg_go();
        cfg_chk(1, 0, 2);
        dx();
        for (int i = 0; i < 6; i++) wv[i] = rnd();
        wr_blk(0, 5, 3'h5);
        rd(3'h0, 2'h3, wv[3]);
        rd(3'h1, 2'h2, wv[5]);
        rd(3'h2, 2'h0, 16'h0);
        link_fault = 1;
        tick();
        chk("lamp on fault", {15'h0, link_err}, 16'h1);
        rd(3'h0, 2'h0, 16'h0);
        link_fault = 0;
        chk("answers left", 16'(exq.size()), 16'h0);
        finish_test();
    end
endmodule
